// >>> include/gpm_irq_if.sv
/*
  Bundle between the register side and the per-pin event detector.
  Assumes all signals live in the hclk domain.
*/
`timescale 1ns/1ps
interface gpm_irq_if #(
  parameter int N = 15
);
  logic [N-1:0] level;
  logic [N-1:0] sense;
  logic [N-1:0] both;
  logic [N-1:0] polarity;
  logic [N-1:0] clear;
  logic [N-1:0] set;
  logic [N-1:0] raw;

  modport ctrl (output level, sense, both, polarity, clear, input set, raw);
  modport det  (input level, sense, both, polarity, clear, output set, raw);
endinterface : gpm_irq_if

// >>> include/gpm_pkg.sv
/*
  Shared constants of the pin multiplexer and interrupt block: register
  offsets, reset values, function codes, per-pin pad facts and timing.
  Assumes a 20 MHz system clock and a byte-addressed 32-bit register bus.
*/
package gpm_pkg;
  // Pin count and function-select layout
  localparam int PIN_MAX = 15;
  localparam int LO_PINS = 8;
  localparam int FSEL_W  = 4;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_PIN_DATA    = 8'h00;
  localparam logic [7:0] OFS_OUT_ENABLE  = 8'h04;
  localparam logic [7:0] OFS_PULL_ENABLE = 8'h08;
  localparam logic [7:0] OFS_DRIVE_HIGH  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_SENSE   = 8'h10;
  localparam logic [7:0] OFS_IRQ_BOTH    = 8'h14;
  localparam logic [7:0] OFS_IRQ_POL     = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_RAW     = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASKED  = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h28;
  localparam logic [7:0] OFS_FSEL_LO     = 8'h2C;
  localparam logic [7:0] OFS_FSEL_HI     = 8'h30;

  // Reset values
  localparam logic [31:0] RST_PULL    = 32'h03FFFFFF;
  localparam logic [31:0] RST_FSEL_LO = 32'h00000000;
  localparam logic [31:0] RST_FSEL_HI = 32'h00000110;

  // Function codes
  localparam logic [2:0] FN_GPIO  = 3'h0;
  localparam logic [2:0] FN_SER_A = 3'h1;
  localparam logic [2:0] FN_SER_B = 3'h4;
  localparam logic [2:0] FN_SER_C = 3'h5;

  // Pad facts: pull direction, pull availability, input-only pins
  localparam logic [14:0] PULL_UP_PINS = 15'h0E00;
  localparam logic [14:0] PULL_AVAIL   = 15'h4FFF;
  localparam logic [14:0] INPUT_ONLY   = 15'h3000;
  localparam int          WAKE_LSB     = 9;
  localparam int          WAKE_NUM     = 5;

  // Reset pulse on the analog test pin
  localparam int CLK_MHZ        = 20;
  localparam int TEST_PULSE_US  = 75;
  localparam int TEST_PULSE_CYC = TEST_PULSE_US * CLK_MHZ;
  localparam int PULSE_W        = $clog2(TEST_PULSE_CYC);

  typedef enum logic {PS_PULSE, PS_RUN} gpm_pulse_t;
endpackage : gpm_pkg

// >>> logic/gpm_irq_detect.sv
/*
  Per-pin edge and level detector with sticky raw status.
  Assumes level is already synchronised and clear is a one-cycle pulse.
*/
`timescale 1ns/1ps
module gpm_irq_detect #(
  parameter int N = 15
) (
  // Clock and reset
  input logic hclk,
  input logic hresetn,
  // Detector side of the bundle
  gpm_irq_if.det irq
);
  logic [N-1:0] prev;

  // Previous level for edge comparison
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) prev <= '0;
    else          prev <= irq.level;
  end

  // Match per pin, independent of the pin's function
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (irq.sense[i])     irq.set[i] = irq.level[i] == irq.polarity[i];
      else if (irq.both[i]) irq.set[i] = irq.level[i] ^ prev[i];
      else if (irq.polarity[i]) irq.set[i] = irq.level[i] & ~prev[i];
      else                  irq.set[i] = ~irq.level[i] & prev[i];
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq.raw <= '0;
    else          irq.raw <= (irq.raw & ~irq.clear) | irq.set;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_rise_sets;
    (!irq.sense[0] && !irq.both[0] && irq.polarity[0] && irq.level[0] && !prev[0])
      |=> irq.raw[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge not latched");

  property p_clear_drops;
    (irq.clear != '0) |=> ((irq.raw & $past(irq.clear & ~irq.set)) == '0);
  endproperty
  a_clear_drops: assert property (p_clear_drops) else $error("clear left status");

  property p_zero_keeps;
    1'b1 |=> ((irq.raw & $past(irq.raw & ~irq.clear)) == $past(irq.raw & ~irq.clear));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("status lost without clear");
endmodule : gpm_irq_detect

// >>> logic/gpm_sync.sv
/*
  Two-flop synchroniser for a vector of pad levels.
  Assumes bits are independent; no word coherence is promised.
*/
`timescale 1ns/1ps
module gpm_sync #(
  parameter int W = 15
) (
  // Clock and reset
  input  logic         hclk,
  input  logic         hresetn,
  // Levels
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : gpm_sync

// >>> logic/gpm_top.sv
/*
  Pin function multiplexer with per-pin interrupt detection and an
  AHB-Lite register slave. Assumes one 20 MHz clock, a power controller
  in the same domain driving low_power, and pads that resolve
  out/oe/pull into the wire level.
*/
// Operation
// - Fourteen or fifteen pins, indexed by number
// - Three-bit function select with four codes
// - First serial set: UART, debug, two-wire A
// - Second set: SPI, two-wire B, two-wire A
// - Two PWM sources on pins two to five
// - Third set: density data in, clock out
// - Five pins wake from sleep and standby
// - Interrupts detect regardless of pin function
// - Sense, both-edge and polarity select trigger
// - A match sets the raw status bit
// - Enable mask bit per pin gates interrupt
// - Writing one to clear drops status
// - All pin interrupts merge into one line
// - Reset pull and function defaults per pin
// - All pins high impedance during reset
// - Low power: fixed pad states per pin
// - Pins twelve and thirteen never drive high
// - Test pin pulses high after reset
// - Masked status equals raw and mask
// - Writing zero to clear changes nothing
`timescale 1ns/1ps
module gpm_top
  import gpm_pkg::*;
#(
  parameter int NUM_PINS = 15
) (
  // Clock and reset
  input  logic                hclk,
  input  logic                hresetn,
  // AHB-Lite slave
  input  logic                hsel,
  input  logic [31:0]         haddr,
  input  logic [1:0]          htrans,
  input  logic                hwrite,
  input  logic [2:0]          hsize,
  input  logic                hready,
  input  logic [31:0]         hwdata,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  // Pads
  input  logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_pull_en,
  output logic [NUM_PINS-1:0] pin_pull_up,
  output logic [NUM_PINS-1:0] pin_drive_high,
  // Power state
  input  logic                low_power,
  // UART
  input  logic                uart_rts,
  input  logic                uart_txd,
  output logic                uart_cts,
  output logic                uart_rxd,
  // Debug
  output logic                swd_clk,
  output logic                swd_dio,
  // SPI
  input  logic                spi_clk_o,
  input  logic                spi_clk_oe,
  input  logic                spi_cs_o,
  input  logic                spi_cs_oe,
  input  logic                spi_mosi,
  output logic                spi_clk_i,
  output logic                spi_cs_i,
  output logic                spi_miso,
  // Two-wire, open drain: a request pulls the line low
  input  logic                twowire_a_clock_low,
  input  logic                twowire_a_data_low,
  input  logic                twowire_b_clock_low,
  input  logic                twowire_b_data_low,
  output logic                twowire_a_clock,
  output logic                twowire_a_data,
  output logic                twowire_b_clock,
  output logic                twowire_b_data,
  // PWM and pulse density
  input  logic                pwm_source_a,
  input  logic                pwm_source_b,
  input  logic                pulse_density_clock_out,
  output logic                pulse_density_data_in,
  // Events
  output logic                irq,
  output logic [WAKE_NUM-1:0] wake_request
);
  if (NUM_PINS < 14 || NUM_PINS > PIN_MAX) begin : g_bad_pins
    $error("NUM_PINS must be 14 or 15");
  end

  logic [PIN_MAX-1:0] pin_ext;
  logic [PIN_MAX-1:0] lvl;
  logic [PIN_MAX-1:0] dout;
  logic [PIN_MAX-1:0] oen;
  logic [PIN_MAX-1:0] pul;
  logic [PIN_MAX-1:0] dstr;
  logic [PIN_MAX-1:0] sen;
  logic [PIN_MAX-1:0] bth;
  logic [PIN_MAX-1:0] pol;
  logic [PIN_MAX-1:0] msk;
  logic [2:0]         md [PIN_MAX];
  logic [1:0]         pd [PIN_MAX];
  logic [PIN_MAX-1:0] next_out;
  logic [PIN_MAX-1:0] next_oe;
  logic [PIN_MAX-1:0] pad_out;
  logic [PIN_MAX-1:0] pad_oe;
  logic [PIN_MAX-1:0] pad_pull;
  logic [PIN_MAX-1:0] pad_up;
  logic [PIN_MAX-1:0] pad_drive;
  logic               ph_wr;
  logic [7:0]         ph_addr;
  logic               wr_go;
  logic [31:0]        rd_val;
  gpm_pulse_t         pstate;
  logic [PULSE_W-1:0] pcnt;

  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(TEST_PULSE_CYC - 1);

  // Missing pin of the small variant reads as low
  assign pin_ext = PIN_MAX'(pin_in);

  gpm_sync #(.W(PIN_MAX)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pin_ext),
    .q       (lvl)
  );

  gpm_irq_if #(.N(PIN_MAX)) irq_bus ();

  gpm_irq_detect #(.N(PIN_MAX)) u_detect (
    .hclk    (hclk),
    .hresetn (hresetn),
    .irq     (irq_bus.det)
  );

  // Detector fed from synced pins, whatever function is selected
  assign irq_bus.level    = lvl;
  assign irq_bus.sense    = sen;
  assign irq_bus.both     = bth;
  assign irq_bus.polarity = pol;
  assign irq_bus.clear    = (wr_go && ph_addr == OFS_IRQ_CLEAR) ? hwdata[PIN_MAX-1:0] : '0;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_go     = ph_wr;

  // Address phase capture; only whole-word writes are accepted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr   <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_wr   <= hsel && htrans[1] && hwrite && hsize == 3'h2;
      ph_addr <= haddr[7:0];
    end
  end

  // Read value decoded from the address phase
  always_comb begin
    rd_val = 32'h00000000;
    case (haddr[7:0])
      OFS_PIN_DATA:    rd_val = 32'(lvl);
      OFS_OUT_ENABLE:  rd_val = 32'(oen);
      OFS_PULL_ENABLE: rd_val = 32'(pul);
      OFS_DRIVE_HIGH:  rd_val = 32'(dstr);
      OFS_IRQ_SENSE:   rd_val = 32'(sen);
      OFS_IRQ_BOTH:    rd_val = 32'(bth);
      OFS_IRQ_POL:     rd_val = 32'(pol);
      OFS_IRQ_ENABLE:  rd_val = 32'(msk);
      OFS_IRQ_RAW:     rd_val = 32'(irq_bus.raw);
      OFS_IRQ_MASKED:  rd_val = 32'(irq_bus.raw & msk);
      OFS_FSEL_LO: begin
        for (int i = 0; i < LO_PINS; i++) rd_val[i*FSEL_W +: 3] = md[i];
      end
      OFS_FSEL_HI: begin
        for (int i = LO_PINS; i < PIN_MAX; i++) rd_val[(i-LO_PINS)*FSEL_W +: 3] = md[i];
      end
      default: rd_val = 32'h00000000;
    endcase
  end

  // Read data registered so it stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite) hrdata <= rd_val;
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout <= '0;
      oen  <= '0;
      pul  <= RST_PULL[PIN_MAX-1:0];
      dstr <= '0;
      sen  <= '0;
      bth  <= '0;
      pol  <= '0;
      msk  <= '0;
      for (int i = 0; i < LO_PINS; i++) md[i] <= RST_FSEL_LO[i*FSEL_W +: 3];
      for (int i = LO_PINS; i < PIN_MAX; i++) begin
        md[i] <= RST_FSEL_HI[(i-LO_PINS)*FSEL_W +: 3];
      end
    end else if (wr_go) begin
      case (ph_addr)
        OFS_PIN_DATA:    dout <= hwdata[PIN_MAX-1:0];
        OFS_OUT_ENABLE:  oen  <= hwdata[PIN_MAX-1:0];
        OFS_PULL_ENABLE: pul  <= hwdata[PIN_MAX-1:0];
        OFS_DRIVE_HIGH:  dstr <= hwdata[PIN_MAX-1:0];
        OFS_IRQ_SENSE:   sen  <= hwdata[PIN_MAX-1:0];
        OFS_IRQ_BOTH:    bth  <= hwdata[PIN_MAX-1:0];
        OFS_IRQ_POL:     pol  <= hwdata[PIN_MAX-1:0];
        OFS_IRQ_ENABLE:  msk  <= hwdata[PIN_MAX-1:0];
        OFS_FSEL_LO: begin
          for (int i = 0; i < LO_PINS; i++) md[i] <= hwdata[i*FSEL_W +: 3];
        end
        OFS_FSEL_HI: begin
          for (int i = LO_PINS; i < PIN_MAX; i++) begin
            md[i] <= hwdata[(i-LO_PINS)*FSEL_W +: 3];
          end
        end
        default: ;
      endcase
    end
  end

  // Function mux: {oe, out} per pin; unlisted codes leave the pin undriven
  always_comb begin
    for (int i = 0; i < PIN_MAX; i++) begin
      pd[i] = (md[i] == FN_GPIO) ? {oen[i] & ~INPUT_ONLY[i], dout[i]} : 2'b00;
    end
    if (md[0]  == FN_SER_B) pd[0]  = {spi_clk_oe, spi_clk_o};
    if (md[1]  == FN_SER_A) pd[1]  = {1'b1, uart_rts};
    if (md[1]  == FN_SER_B) pd[1]  = {spi_cs_oe, spi_cs_o};
    if (md[2]  == FN_SER_A) pd[2]  = {1'b1, pwm_source_a};
    if (md[2]  == FN_SER_B) pd[2]  = {1'b1, spi_mosi};
    if (md[2]  == FN_SER_C) pd[2]  = {1'b1, pulse_density_clock_out};
    if (md[3]  == FN_SER_A) pd[3]  = {1'b1, pwm_source_b};
    if (md[4]  == FN_SER_B) pd[4]  = {twowire_b_clock_low, 1'b0};
    if (md[4]  == FN_SER_C) pd[4]  = {1'b1, pwm_source_a};
    if (md[5]  == FN_SER_A) pd[5]  = {1'b1, uart_txd};
    if (md[5]  == FN_SER_B) pd[5]  = {twowire_b_data_low, 1'b0};
    if (md[5]  == FN_SER_C) pd[5]  = {1'b1, pwm_source_b};
    if (md[6]  == FN_SER_A) pd[6]  = {1'b1, uart_rts};
    if (md[6]  == FN_SER_B) pd[6]  = {twowire_b_clock_low, 1'b0};
    if (md[7]  == FN_SER_B) pd[7]  = {twowire_b_data_low, 1'b0};
    if (md[7]  == FN_SER_C) pd[7]  = {1'b1, pulse_density_clock_out};
    if (md[8]  == FN_SER_A) pd[8]  = {1'b1, uart_txd};
    if (md[8]  == FN_SER_B) pd[8]  = {spi_clk_oe, spi_clk_o};
    if (md[10] == FN_SER_B) pd[10] = {1'b1, spi_mosi};
    if (md[11] == FN_SER_B) pd[11] = {spi_cs_oe, spi_cs_o};
    if (md[12] == FN_SER_B) pd[12] = {twowire_a_clock_low, 1'b0};
    if (md[13] == FN_SER_B) pd[13] = {twowire_a_data_low, 1'b0};
    if (md[14] == FN_SER_A) pd[14] = {twowire_a_clock_low, 1'b0};
    if (md[14] == FN_SER_B) pd[14] = {spi_clk_oe, spi_clk_o};
    for (int i = 0; i < PIN_MAX; i++) begin
      next_oe[i]  = pd[i][1] & ~low_power;
      next_out[i] = pd[i][0];
    end
    if (pstate == PS_PULSE) begin
      next_oe[14]  = 1'b1;
      next_out[14] = 1'b1;
    end
  end

  // Pad drive registered; all zero during reset leaves every pin floating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out   <= '0;
      pad_oe    <= '0;
      pad_pull  <= '0;
      pad_up    <= '0;
      pad_drive <= '0;
    end else begin
      pad_out   <= next_out;
      pad_oe    <= next_oe;
      pad_pull  <= low_power ? PULL_UP_PINS : (pul & PULL_AVAIL);
      pad_up    <= PULL_UP_PINS;
      pad_drive <= dstr;
    end
  end

  assign pin_out        = pad_out[NUM_PINS-1:0];
  assign pin_oe         = pad_oe[NUM_PINS-1:0];
  assign pin_pull_en    = pad_pull[NUM_PINS-1:0];
  assign pin_pull_up    = pad_up[NUM_PINS-1:0];
  assign pin_drive_high = pad_drive[NUM_PINS-1:0];

  // Peripheral inputs: lowest listed pin in the matching set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uart_cts              <= 1'b1;
      uart_rxd              <= 1'b1;
      swd_clk               <= 1'b0;
      swd_dio               <= 1'b0;
      spi_clk_i             <= 1'b0;
      spi_cs_i              <= 1'b1;
      spi_miso              <= 1'b0;
      twowire_a_clock       <= 1'b1;
      twowire_a_data        <= 1'b1;
      twowire_b_clock       <= 1'b1;
      twowire_b_data        <= 1'b1;
      pulse_density_data_in <= 1'b0;
    end else begin
      uart_cts <= (md[0] == FN_SER_A) ? lvl[0] : (md[7] == FN_SER_A) ? lvl[7] :
                  (md[13] == FN_SER_A) ? lvl[13] : 1'b1;
      uart_rxd <= (md[4] == FN_SER_A) ? lvl[4] : (md[11] == FN_SER_A) ? lvl[11] : 1'b1;
      swd_clk  <= (md[9] == FN_SER_A) & lvl[9];
      swd_dio  <= (md[10] == FN_SER_A) & lvl[10];
      spi_clk_i <= (md[0] == FN_SER_B) ? lvl[0] : (md[8] == FN_SER_B) ? lvl[8] :
                   (md[14] == FN_SER_B) ? lvl[14] : 1'b0;
      spi_cs_i <= (md[1] == FN_SER_B) ? lvl[1] : (md[11] == FN_SER_B) ? lvl[11] : 1'b1;
      spi_miso <= (md[3] == FN_SER_B) ? lvl[3] : (md[9] == FN_SER_B) ? lvl[9] : 1'b0;
      twowire_a_clock <= (md[12] == FN_SER_B) ? lvl[12] :
                         (md[14] == FN_SER_A) ? lvl[14] : 1'b1;
      twowire_a_data  <= (md[13] == FN_SER_B) ? lvl[13] : 1'b1;
      twowire_b_clock <= (md[4] == FN_SER_B) ? lvl[4] : (md[6] == FN_SER_B) ? lvl[6] : 1'b1;
      twowire_b_data  <= (md[5] == FN_SER_B) ? lvl[5] : (md[7] == FN_SER_B) ? lvl[7] : 1'b1;
      pulse_density_data_in <= (md[1] == FN_SER_C) ? lvl[1] : (md[6] == FN_SER_C) ? lvl[6] :
                               (md[8] == FN_SER_C) ? lvl[8] : 1'b0;
    end
  end

  // Combined interrupt and wake requests; wake uses raw status so it
  // works with the mask cleared while the core sleeps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq          <= 1'b0;
      wake_request <= '0;
    end else begin
      irq          <= |(irq_bus.raw & msk);
      wake_request <= irq_bus.raw[WAKE_LSB +: WAKE_NUM];
    end
  end

  // Test-pin pulse right after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pstate <= PS_PULSE;
      pcnt   <= '0;
    end else begin
      unique case (pstate)
        PS_PULSE: begin
          if (pcnt == PULSE_LAST) pstate <= PS_RUN;
          else pcnt <= pcnt + PULSE_W'(1);
        end
        PS_RUN: ;
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_irq_merge;
    (|(irq_bus.raw & msk)) |=> irq;
  endproperty
  a_irq_merge: assert property (p_irq_merge) else $error("pending bit not on irq");

  property p_mask_write;
    (wr_go && ph_addr == OFS_IRQ_ENABLE) |=> (msk == $past(hwdata[PIN_MAX-1:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_low_power;
    low_power |=> (pad_oe == '0) && (pad_pull == PULL_UP_PINS);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power pad state wrong");

  property p_open_drain;
    (md[12] == FN_GPIO && md[13] == FN_GPIO) |=> !pad_oe[12] && !pad_oe[13];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("input-only pin driven");

  property p_pulse_drive;
    (pstate == PS_PULSE) |=> pad_oe[14] && pad_out[14];
  endproperty
  a_pulse_drive: assert property (p_pulse_drive) else $error("test pulse not driven");

  property p_pulse_end;
    (pstate == PS_PULSE && pcnt == PULSE_LAST) |=> (pstate == PS_RUN);
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("test pulse length wrong");

  property p_sync_delay;
    1'b1 |-> ##2 (lvl == $past(pin_ext, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("pin sync delay wrong");

  property p_pwm_route;
    (md[2] == FN_SER_A && !low_power && pstate == PS_RUN)
      |=> pad_oe[2] && (pad_out[2] == $past(pwm_source_a));
  endproperty
  a_pwm_route: assert property (p_pwm_route) else $error("pwm not routed");

  c_irq_fire:  cover property (!irq ##1 irq);
  c_clear:     cover property (irq_bus.clear != '0);
  c_low_power: cover property (low_power ##1 !low_power);
endmodule : gpm_top

// >>> sim/gpm_pad_model.sv
/*
  Pad model for the pin block: resolves what each pad reads back.
  Assumes the outside world always drives an undriven pad from ext_val.
*/
`timescale 1ns/1ps
module gpm_pad_model #(
  parameter int N = 15
) (
  // Pad controls from the block
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe,
  // Outside level and resolved pad
  input  wire logic [N-1:0] ext_val,
  output logic      [N-1:0] pin_in
);
  // Block drive wins over the outside driver
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule : gpm_pad_model

// >>> sim/test_gpio_pin_mux_irq.sv
/*
  Self-checking bench for the pin mux and interrupt block.
  Assumes a zero-wait AHB-Lite slave and the pad model beside it.
*/
`timescale 1ns/1ps
module test_gpio_pin_mux_irq;
  import gpm_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, low_power, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r, d;
  logic [14:0] pin_in, pin_out, pin_oe, pull_en, pull_up, ext_val;
  logic [13:0] pi;
  logic        a, b;
  logic [4:0]  wk;
  int          fails, compares, cyc, p;
  gpm_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_en(pull_en), .pin_pull_up(pull_up), .pin_drive_high(), .low_power(low_power),
    .uart_rts(pi[0]), .uart_txd(pi[1]), .uart_cts(), .uart_rxd(), .swd_clk(), .swd_dio(),
    .spi_clk_o(pi[2]), .spi_clk_oe(pi[3]), .spi_cs_o(pi[4]), .spi_cs_oe(pi[5]),
    .spi_mosi(pi[6]), .spi_clk_i(), .spi_cs_i(), .spi_miso(), .twowire_a_clock_low(pi[7]),
    .twowire_a_data_low(pi[8]), .twowire_b_clock_low(pi[9]), .twowire_b_data_low(pi[10]),
    .twowire_a_clock(), .twowire_a_data(), .twowire_b_clock(), .twowire_b_data(),
    .pwm_source_a(pi[11]), .pwm_source_b(pi[12]), .pulse_density_clock_out(pi[13]),
    .pulse_density_data_in(), .irq(irq), .wake_request(wk));
  gpm_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in));

  task summarize;
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One single transfer; address held until hready, then the data phase
  task xfer(input logic [7:0] ad, input logic wr, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  // Expected raw bit: modes 0 fall, 1 rise, 2 both, 3 low, 4 high
  function logic ev(int m, logic x, logic y);
    if (m > 2)
      return (x == (m == 4)) || (y == (m == 4));
    return (x != y) && (m == 2 || y == (m == 1));
  endfunction : ev

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Hang guard; the long reset pulse dominates the run time
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, low_power, htrans, haddr, hwdata, pi, ext_val} = '0;
    p = $urandom(78202);
    repeat (4) @(posedge hclk);
    chk({pin_oe, pull_en}, 0);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({pin_oe[14], pin_out[14]}, 2'h3);
    chk(pull_en, PULL_AVAIL);
    chk(pull_up & PULL_AVAIL, PULL_UP_PINS & PULL_AVAIL);
    xfer(OFS_FSEL_HI, 1'b0, 0);
    chk(r, RST_FSEL_HI);
    repeat (TEST_PULSE_CYC) @(posedge hclk);
    chk(pin_oe[14], 1'b0);
    xfer(8'h40, 1'b0, 0);
    chk(r, 0);
    // Every trigger mode on a random pin with random before and after levels
    for (int m = 0; m < 5; m++) begin
      p = $urandom % 12;
      a = 1'($urandom);
      b = 1'($urandom);
      ext_val[p] <= a;
      xfer(OFS_IRQ_SENSE, 1'b1, 32'(m > 2) << p);
      xfer(OFS_IRQ_BOTH, 1'b1, 32'(m == 2) << p);
      xfer(OFS_IRQ_POL, 1'b1, 32'(m == 1 || m == 4) << p);
      repeat (6) @(posedge hclk);
      xfer(OFS_IRQ_CLEAR, 1'b1, 32'h7FFF);
      repeat (6) @(posedge hclk);
      ext_val[p] <= b;
      repeat (6) @(posedge hclk);
      xfer(OFS_IRQ_RAW, 1'b0, 0);
      chk(r[p], ev(m, a, b));
    end
    // High level held, cleared first, then unmasked
    ext_val[p] <= 1'b1;
    xfer(OFS_IRQ_CLEAR, 1'b1, 32'h7FFF);
    xfer(OFS_IRQ_ENABLE, 1'b1, 32'h1 << p);
    repeat (4) @(posedge hclk);
    xfer(OFS_IRQ_MASKED, 1'b0, 0);
    chk(r, 32'h1 << p);
    chk(irq, 1'b1);
    ext_val[p] <= 1'b0;
    xfer(OFS_IRQ_CLEAR, 1'b1, 0);
    repeat (4) @(posedge hclk);
    xfer(OFS_IRQ_RAW, 1'b0, 0);
    chk(r[p], 1'b1);
    xfer(OFS_IRQ_CLEAR, 1'b1, 32'h1 << p);
    repeat (4) @(posedge hclk);
    xfer(OFS_IRQ_RAW, 1'b0, 0);
    chk({r[p], irq}, 2'h0);
    // All pins GPIO with random data; every pin but input-only twelve and thirteen drives
    d = $urandom;
    xfer(OFS_FSEL_HI, 1'b1, 0);
    xfer(OFS_PIN_DATA, 1'b1, d);
    xfer(OFS_OUT_ENABLE, 1'b1, 32'h7FFF);
    repeat (3) @(posedge hclk);
    chk(pin_oe, 15'h7FFF & ~INPUT_ONLY);
    xfer(OFS_PIN_DATA, 1'b0, 0);
    chk(r, (d[14:0] & ~INPUT_ONLY) | (ext_val & INPUT_ONLY));
    xfer(OFS_OUT_ENABLE, 1'b1, 0);
    // PWM sources on pins two to five in sets A and C
    pi <= 14'($urandom);
    xfer(OFS_FSEL_LO, 1'b1, 32'h00551100);
    repeat (3) @(posedge hclk);
    chk({pin_oe[5:2], pin_out[5:2]}, {4'hF, pi[12], pi[11], pi[12], pi[11]});
    low_power <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({pin_oe, pull_en}, 30'h0E00);
    // Falling edge on the input-only pin raises its wake request in low power
    xfer(OFS_IRQ_CLEAR, 1'b1, 32'h7FFF);
    ext_val[12] <= 1'b1;
    repeat (4) @(posedge hclk);
    ext_val[12] <= 1'b0;
    repeat (5) @(posedge hclk);
    chk(wk, 5'h08);
    summarize();
  end
endmodule : test_gpio_pin_mux_irq
